// ### rtl/rwpg_top.sv
// Rectangle wave pattern generator with APB registers and capture counter
//
// Local design decisions: the register addresses and the APB slave port.
`default_nettype none
module rwpg_top
    import rwpg_pkg::*;
#(
    parameter int ANG_W = 16,
    parameter int CNT_W = 24
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Measured resolver angle
    input  wire logic [15:0] resolver_angle,
    // Phase outputs
    output logic             u_phase,
    output logic             v_phase,
    output logic             w_phase,
    // Downstream output stage and interrupt request
    output logic [2:0]       downstream_output_stage,
    output logic             compare_irq
);
    initial begin
        if (ANG_W != 16) $error("ANG_W must be 16");
    end

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic                unlocked;
        logic                run;
        logic [7:0]          ang_src;
        logic [7:0]          poles;
        logic [15:0]         mult;
        logic [15:0]         offset;
        logic [7:0]          mode;
        logic [7:0]          sw_src;
        logic [2:0]          instr;
        logic [15:0]         qcorr;
        logic [2:0]          pattern;
        logic [15:0]         cmp;
        logic [7:0]          trig;
        logic [31:0]         irq_sel;
        logic [15:0]         sw_angle;
        logic [8:0]          route0;
        logic [8:0]          route1;
        logic [8:0]          route2;
        rwpg_state_type      fsm;
        logic [15:0]         elec;
        logic                match_prev;
        logic [2:0]          step;
        logic [7:0]          match_cnt;
        rwpg_phase_type      phase;
        logic [2:0]          ds;
        logic                irq;
        logic [31:0]         rdata;
        logic                ready;
        logic                slverr;
        logic                cap_clear;
    } rwpg_state_reg_type;

    rwpg_state_reg_type st_reg;
    rwpg_state_reg_type st_next;
    logic [CNT_W-1:0]   cap_cnt;
    logic               cap_run;
    logic               cap_src;
    logic [15:0]        angle_in;
    logic [31:0]        scaled;
    logic [15:0]        cmp_eff;
    logic               match;
    logic               acc;
    logic               wr;

    ////////////////////////////////////////////////////////////////////////////
    // Angle path
    always_comb begin
        angle_in = (st_reg.ang_src == ANG_SRC_SW) ? st_reg.sw_angle : resolver_angle;
        angle_in = angle_in + st_reg.offset;
        scaled   = angle_in * st_reg.mult;
        cmp_eff  = st_reg.cmp + st_reg.qcorr;
        match    = (st_reg.elec == cmp_eff);
    end

    // Capture input routing selects which phase reaches channel zero
    always_comb begin
        case (st_reg.route0)
            ROUTE_U: cap_src = st_reg.phase.u;
            ROUTE_V: cap_src = st_reg.phase.v;
            ROUTE_W: cap_src = st_reg.phase.w;
            default: cap_src = 1'b1;
        endcase
    end

    assign acc = psel && penable && !st_reg.ready;
    assign wr  = acc && pwrite;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.ready     = 1'b0;
        st_next.slverr    = 1'b0;
        st_next.cap_clear = 1'b0;
        st_next.elec      = scaled[MULT_FRAC +: 16];
        st_next.match_prev = match;
        st_next.irq       = 1'b0;

        // APB write; protected registers need the key open
        if (wr) begin
            st_next.ready = 1'b1;
            if (paddr == OFS_KEY) begin
                if (pwdata[7:0] == KEY_OPEN) st_next.unlocked = 1'b1;
                if (pwdata[7:0] == KEY_SHUT) st_next.unlocked = 1'b0;
            end else if (paddr == OFS_CAPTURE) begin
                st_next.cap_clear = 1'b1;
            end else if (!st_reg.unlocked) begin
                st_next.slverr = 1'b1;
            end else begin
                case (paddr)
                    OFS_RUN:      st_next.run      = pwdata[0];
                    OFS_ANG_SRC:  st_next.ang_src  = pwdata[7:0];
                    OFS_POLES:    st_next.poles    = pwdata[7:0];
                    OFS_MULT:     st_next.mult     = pwdata[15:0];
                    OFS_OFFSET:   st_next.offset   = pwdata[15:0];
                    OFS_MODE:     st_next.mode     = pwdata[7:0];
                    OFS_SW_SRC:   st_next.sw_src   = pwdata[7:0];
                    OFS_SW_INSTR: begin
                        if (pwdata[2:0] > INSTR_LAST) st_next.slverr = 1'b1;
                        else st_next.instr = pwdata[2:0];
                    end
                    OFS_QCORR:    st_next.qcorr    = pwdata[15:0];
                    OFS_PATTERN:  st_next.pattern  = pwdata[2:0];
                    OFS_CMP:      st_next.cmp      = pwdata[15:0];
                    OFS_TRIG:     st_next.trig     = pwdata[7:0];
                    OFS_IRQ_SEL:  st_next.irq_sel  = pwdata;
                    OFS_SW_ANGLE: st_next.sw_angle = pwdata[15:0];
                    OFS_ROUTE0: begin
                        st_next.route0 = pwdata[8:0];
                        st_next.route1 = pwdata[24:16];
                    end
                    OFS_ROUTE1:   st_next.route2   = pwdata[8:0];
                    default:      st_next.slverr   = 1'b1;
                endcase
            end
        end

        // APB read
        if (acc && !pwrite) begin
            st_next.ready = 1'b1;
            st_next.rdata = '0;
            case (paddr)
                OFS_KEY:      st_next.rdata[0]     = st_reg.unlocked;
                OFS_RUN:      st_next.rdata[0]     = st_reg.run;
                OFS_ANG_SRC:  st_next.rdata[7:0]   = st_reg.ang_src;
                OFS_POLES:    st_next.rdata[7:0]   = st_reg.poles;
                OFS_MULT:     st_next.rdata[15:0]  = st_reg.mult;
                OFS_OFFSET:   st_next.rdata[15:0]  = st_reg.offset;
                OFS_MODE:     st_next.rdata[7:0]   = st_reg.mode;
                OFS_SW_SRC:   st_next.rdata[7:0]   = st_reg.sw_src;
                OFS_SW_INSTR: st_next.rdata[2:0]   = st_reg.instr;
                OFS_QCORR:    st_next.rdata[15:0]  = st_reg.qcorr;
                OFS_PATTERN:  st_next.rdata[2:0]   = st_reg.pattern;
                OFS_CMP:      st_next.rdata[15:0]  = st_reg.cmp;
                OFS_TRIG:     st_next.rdata[7:0]   = st_reg.trig;
                OFS_IRQ_SEL:  st_next.rdata        = st_reg.irq_sel;
                OFS_SW_ANGLE: st_next.rdata[15:0]  = st_reg.sw_angle;
                OFS_ROUTE0:   st_next.rdata        = {7'h00, st_reg.route1, 7'h00, st_reg.route0};
                OFS_ROUTE1:   st_next.rdata[8:0]   = st_reg.route2;
                OFS_STATUS:   st_next.rdata        = {5'h00, st_reg.step, st_reg.match_cnt, st_reg.elec};
                OFS_CAPTURE:  st_next.rdata        = {cap_run, 7'h00, 24'(cap_cnt)};
                default:      st_next.slverr       = 1'b1;
            endcase
        end

        // Generator sequencer: a compare match steps the pattern
        case (st_reg.fsm)
            RWPG_IDLE: begin
                if (st_reg.run) st_next.fsm = RWPG_ARM;
            end
            RWPG_ARM: begin
                if (!st_reg.run) st_next.fsm = RWPG_IDLE;
                else if (st_reg.trig == TRIG_ANG_MATCH && match && !st_reg.match_prev) begin
                    st_next.fsm = RWPG_RUN;
                end
            end
            RWPG_RUN: begin
                if (!st_reg.run) st_next.fsm = RWPG_IDLE;
            end
            default: st_next.fsm = RWPG_IDLE;
        endcase

        // Each new match in run state, or in arm with angle-match trigger, takes the next pattern, six per cycle
        if (st_reg.fsm != RWPG_IDLE && match && !st_reg.match_prev) begin
            st_next.match_cnt = st_reg.match_cnt + 1'b1;
            if (st_reg.irq_sel == IRQ_MATCH_EN) st_next.irq = 1'b1;
            if (st_reg.fsm == RWPG_RUN || st_reg.trig == TRIG_ANG_MATCH) begin
                if (st_reg.sw_src == SW_SRC_SOFT) begin
                    st_next.step = st_reg.instr;
                end else begin
                    st_next.step = (st_reg.step == INSTR_LAST) ? 3'h0 : st_reg.step + 1'b1;
                end
                st_next.phase.u = st_reg.pattern[PAT_U];
                st_next.phase.v = st_reg.pattern[PAT_V];
                st_next.phase.w = st_reg.pattern[PAT_W];
            end
        end
        if (st_reg.fsm == RWPG_IDLE) st_next.phase = PHASE_LOW;

        // Batch pattern forwarded to the downstream stage
        st_next.ds = (st_reg.mode == MODE_BATCH) ? st_reg.phase : PHASE_LOW;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg          <= '0;
            st_reg.mult     <= MULT_RESET;
            st_reg.offset   <= OFFSET_RESET;
            st_reg.qcorr    <= QCORR_RESET;
            st_reg.fsm      <= RWPG_IDLE;
            st_reg.route0   <= ROUTE_U;
            st_reg.route1   <= ROUTE_V;
            st_reg.route2   <= ROUTE_W;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture counter fed by the routed phase
    rwpg_capture_counter #(
        .CNT_W (CNT_W)
    ) u_cap (
        .core_clk                (core_clk),
        .resetn                  (resetn),
        .clear                   (st_reg.cap_clear),
        .capture_input_zero      (cap_src),
        .capture_channel_counter (cap_cnt),
        .counting                (cap_run)
    );

    // Outputs from flip-flops
    assign prdata                  = st_reg.rdata;
    assign pready                  = st_reg.ready;
    assign pslverr                 = st_reg.slverr;
    assign u_phase                 = st_reg.phase.u;
    assign v_phase                 = st_reg.phase.v;
    assign w_phase                 = st_reg.phase.w;
    assign downstream_output_stage = st_reg.ds;
    assign compare_irq             = st_reg.irq;
endmodule : rwpg_top
`default_nettype wire

// ### rtl/rwpg_pkg.sv
// Package with register map, field layout and state types of the rectangle wave pattern generator
// Overview of operation
// - Six switching patterns form one electrical cycle
// - Pattern bit one drives phase high
// - Key 0x01 unlocks, 0x00 relocks registers
// - Source select 0x01 uses software angle
// - Multiplier scales angle, reset 0x0100
// - Offset added to selected resolver or software angle, reset zero
// - Mode 0x00 forwards batch pattern downstream
// - Switch source 0x04 uses software instruction
// - Trigger select 0x10 starts on compare match
// - Electrical angle compared with software value
// - Phase correction added before match detection
// - Source select 0x80 enables match interrupt request
// - Capture counter starts on U falling edge
// - Routing codes 0x75..0x77 connect U,V,W
`default_nettype none
package rwpg_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_KEY        = 8'h00;
    localparam logic [7:0] OFS_RUN        = 8'h04;
    localparam logic [7:0] OFS_ANG_SRC    = 8'h08;
    localparam logic [7:0] OFS_POLES      = 8'h0C;
    localparam logic [7:0] OFS_MULT       = 8'h10;
    localparam logic [7:0] OFS_OFFSET     = 8'h14;
    localparam logic [7:0] OFS_MODE       = 8'h18;
    localparam logic [7:0] OFS_SW_SRC     = 8'h1C;
    localparam logic [7:0] OFS_SW_INSTR   = 8'h20;
    localparam logic [7:0] OFS_QCORR      = 8'h24;
    localparam logic [7:0] OFS_PATTERN    = 8'h28;
    localparam logic [7:0] OFS_CMP        = 8'h2C;
    localparam logic [7:0] OFS_TRIG       = 8'h30;
    localparam logic [7:0] OFS_IRQ_SEL    = 8'h34;
    localparam logic [7:0] OFS_SW_ANGLE   = 8'h38;
    localparam logic [7:0] OFS_ROUTE0     = 8'h3C;
    localparam logic [7:0] OFS_ROUTE1     = 8'h40;
    localparam logic [7:0] OFS_STATUS     = 8'h44;
    localparam logic [7:0] OFS_CAPTURE    = 8'h48;
    // Codes and reset values
    localparam logic [7:0]  KEY_OPEN      = 8'h01;
    localparam logic [7:0]  KEY_SHUT      = 8'h00;
    localparam logic [7:0]  ANG_SRC_SW    = 8'h01;
    localparam logic [15:0] MULT_RESET    = 16'h0100;
    localparam logic [15:0] OFFSET_RESET  = 16'h0000;
    localparam logic [15:0] QCORR_RESET   = 16'h0000;
    localparam logic [7:0]  MODE_BATCH    = 8'h00;
    localparam logic [7:0]  SW_SRC_SOFT   = 8'h04;
    localparam logic [7:0]  TRIG_ANG_MATCH = 8'h10;
    localparam logic [31:0] IRQ_MATCH_EN  = 32'h0000_0080;
    localparam logic [8:0]  ROUTE_U       = 9'h075;
    localparam logic [8:0]  ROUTE_V       = 9'h076;
    localparam logic [8:0]  ROUTE_W       = 9'h077;
    localparam logic [2:0]  INSTR_LAST    = 3'h5;
    localparam int          MULT_FRAC     = 8;
    // Pattern field positions
    localparam int PAT_U = 0;
    localparam int PAT_V = 1;
    localparam int PAT_W = 2;
    localparam logic [2:0] PHASE_LOW      = 3'h0;

    // Generator states, Gray along the usual path
    typedef enum logic [1:0] {
        RWPG_IDLE = 2'b00,
        RWPG_ARM  = 2'b01,
        RWPG_RUN  = 2'b11
    } rwpg_state_type;

    // APB request bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } rwpg_apb_req_type;

    // Phase outputs
    typedef struct packed {
        logic w;
        logic v;
        logic u;
    } rwpg_phase_type;
endpackage : rwpg_pkg
`default_nettype wire

// ### rtl/rwpg_capture_counter.sv
// Capture channel counter started by a falling edge of a routed phase
`default_nettype none
module rwpg_capture_counter
    import rwpg_pkg::*;
#(
    parameter int CNT_W = 24
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             resetn,
    // Control
    input  wire logic             clear,
    input  wire logic             capture_input_zero,
    // Result
    output logic [CNT_W-1:0]      capture_channel_counter,
    output logic                  counting
);
    initial begin
        if (CNT_W < 2 || CNT_W > 32) $error("CNT_W out of range");
    end

    typedef struct packed {
        logic             prev;
        logic             run;
        logic [CNT_W-1:0] cnt;
    } rwpg_cap_state_type;

    rwpg_cap_state_type st_reg;
    rwpg_cap_state_type st_next;

    // Start on falling edge, then count every cycle
    always_comb begin
        st_next = st_reg;
        st_next.prev = capture_input_zero;
        if (clear) begin
            // An edge in the clear cycle still starts the count
            st_next.run = st_reg.prev && !capture_input_zero;
            st_next.cnt = '0;
        end else if (st_reg.run) begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end else if (st_reg.prev && !capture_input_zero) begin
            st_next.run = 1'b1;
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign capture_channel_counter = st_reg.cnt;
    assign counting                = st_reg.run;
endmodule : rwpg_capture_counter
`default_nettype wire

// ### dv/rwpg_capture_model.sv
// Behavioural capture channel that counts clocks after a U phase falling edge
`default_nettype none
module rwpg_capture_model (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Watched signals
    input  wire logic        clear,
    input  wire logic        u_phase,
    // Model state
    output logic [23:0]      count,
    output logic             running
);
    logic u_last;
    // Idle until the first U falling edge, then count every clock
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            u_last <= 1'b0;
            count <= 24'h0;
            running <= 1'b0;
        end else begin
            u_last <= u_phase;
            if (clear) begin
                running <= u_last && !u_phase;
                count <= 24'h0;
            end else if (running) begin
                count <= count + 24'h1;
            end else if (u_last && !u_phase) begin
                running <= 1'b1;
            end
        end
    end
endmodule // rwpg_capture_model
`default_nettype wire

// ### dv/rwpg_props.sv
// Port level assertions for the rectangle wave pattern generator
`default_nettype none
module rwpg_props
    import rwpg_pkg::*;
#(
    parameter int ANG_W = 16,
    parameter int CNT_W = 24
) (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Phases and events
    input wire logic        u_phase,
    input wire logic        v_phase,
    input wire logic        w_phase,
    input wire logic [2:0]  downstream_output_stage,
    input wire logic        compare_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic unlocked_reg;
    logic unlocked_next;
    // Unlock state followed from completed key writes
    always_comb begin
        unlocked_next = unlocked_reg;
        if (pready && psel && penable && pwrite && paddr == OFS_KEY && pwdata[7:0] == KEY_OPEN)
            unlocked_next = 1'b1;
        if (pready && psel && penable && pwrite && paddr == OFS_KEY && pwdata[7:0] == KEY_SHUT)
            unlocked_next = 1'b0;
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) unlocked_reg <= 1'b0;
        else unlocked_reg <= unlocked_next;
    end
    ////////////////////////////////////////
    // Bus transfer steps
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_ready_bounded: assert property (s_setup ##1 s_access |-> ##[0:3] pready)
        else $error("no pready after access phase");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready |-> psel && penable && $past(penable))
        else $error("pready outside an access phase");
    a_err_paired: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_locked_refuse: assert property (pready && pwrite && !unlocked_reg && paddr != OFS_KEY
        && paddr != OFS_CAPTURE |-> pslverr) else $error("locked write not refused");
    a_instr_refuse: assert property (pready && pwrite && paddr == OFS_SW_INSTR
        && pwdata[2:0] > INSTR_LAST |-> pslverr) else $error("bad instruction accepted");
    a_stage_copy: assert property (downstream_output_stage != 3'h0
        |-> downstream_output_stage == $past({w_phase, v_phase, u_phase})) else $error("stage not phase copy");
    a_irq_single: assert property (compare_irq |=> !compare_irq)
        else $error("compare irq longer than one cycle");
endmodule // rwpg_props
bind rwpg_top rwpg_props #(.ANG_W(ANG_W), .CNT_W(CNT_W)) u_rwpg_props (.core_clk(core_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .u_phase(u_phase), .v_phase(v_phase), .w_phase(w_phase),
    .downstream_output_stage(downstream_output_stage), .compare_irq(compare_irq));
`default_nettype wire

// ### dv/rwpg_tb_top.sv
// Self-checking bench for the rectangle wave pattern generator
`default_nettype none
module rwpg_tb_top
    import rwpg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0]  instr;
        logic [2:0]  pat;
        logic [15:0] cmp;
    } rwpg_row_type;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] resolver_angle = 16'h0234;
    logic        cap_clear = 1'b0;
    logic [31:0] prdata, rdata;
    logic        pready, pslverr, u_phase, v_phase, w_phase, compare_irq, cap_run, err;
    logic [2:0]  downstream_output_stage;
    logic [23:0] cap_count, diff;
    int          mismatches = 0;
    int          comparisons = 0;
    // Six steps: instruction, pattern and compare value
    rwpg_row_type rows [6] = '{'{3'h0, 3'h1, 16'h0155}, '{3'h1, 3'h3, 16'h02AA}, '{3'h2, 3'h2, 16'h0555},
        '{3'h3, 3'h6, 16'h0800}, '{3'h4, 3'h4, 16'h0AAA}, '{3'h5, 3'h5, 16'h0000}};
    // Setup writes as address and data
    logic [39:0] cfg [8] = '{{OFS_SW_ANGLE, 32'hFFF}, {OFS_ANG_SRC, 24'h0, ANG_SRC_SW}, {OFS_POLES, 32'h1},
        {OFS_MODE, 24'h0, MODE_BATCH}, {OFS_SW_SRC, 24'h0, SW_SRC_SOFT},
        {OFS_TRIG, 24'h0, TRIG_ANG_MATCH}, {OFS_IRQ_SEL, IRQ_MATCH_EN}, {OFS_RUN, 32'h1}};
    always #2.5 core_clk = ~core_clk;
    rwpg_top #(.ANG_W(16), .CNT_W(24)) dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .resolver_angle(resolver_angle), .u_phase(u_phase), .v_phase(v_phase), .w_phase(w_phase),
        .downstream_output_stage(downstream_output_stage), .compare_irq(compare_irq));
    rwpg_capture_model partner (.core_clk(core_clk), .resetn(resetn), .clear(cap_clear), .u_phase(u_phase),
        .count(cap_count), .running(cap_run));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; d is write data or expected read data under mask m
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check($sformatf("error flag at %h", a), {31'h0, e}, {31'h0, err});
        if (!w) check($sformatf("read data at %h", a), d & m, rdata & m);
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (compare_irq !== 1'b1 && n < 20);
        check("compare irq", 32'h1, {31'h0, compare_irq});
    endtask
    // Load pattern and compare value, then move the angle onto the match
    task automatic step(input logic [2:0] p, input logic [15:0] c, input logic [15:0] ang);
        acc(1'b1, OFS_PATTERN, {29'h0, p}, 32'h0, 1'b0);
        acc(1'b1, OFS_CMP, {16'h0, c}, 32'h0, 1'b0);
        acc(1'b1, OFS_SW_ANGLE, {16'h0, ang}, 32'h0, 1'b0);
        wait_irq();
        check("phase levels", {29'h0, p}, {29'h0, w_phase, v_phase, u_phase});
        @(posedge core_clk);
        #1;
        check("downstream stage", {29'h0, p}, {29'h0, downstream_output_stage});
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #250us;
        mismatches++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        acc(1'b0, OFS_MULT, {16'h0, MULT_RESET}, 32'hFFFF, 1'b0);
        acc(1'b0, OFS_OFFSET, {16'h0, OFFSET_RESET}, 32'hFFFF, 1'b0);
        acc(1'b0, OFS_QCORR, {16'h0, QCORR_RESET}, 32'hFFFF, 1'b0);
        acc(1'b0, OFS_ROUTE0, {7'h0, ROUTE_V, 7'h0, ROUTE_U}, 32'h01FF_01FF, 1'b0);
        acc(1'b0, OFS_ROUTE1, {23'h0, ROUTE_W}, 32'h1FF, 1'b0);
        acc(1'b1, OFS_MULT, 32'h300, 32'h0, 1'b1);
        acc(1'b0, OFS_MULT, {16'h0, MULT_RESET}, 32'hFFFF, 1'b0);
        acc(1'b1, OFS_KEY, {24'h0, KEY_OPEN}, 32'h0, 1'b0);
        acc(1'b0, OFS_KEY, 32'h1, 32'h1, 1'b0);
        acc(1'b0, OFS_STATUS, {16'h0, resolver_angle}, 32'hFFFF, 1'b0);
        acc(1'b1, OFS_CAPTURE, 32'h0, 32'h0, 1'b0);
        cap_clear <= 1'b1;
        @(posedge core_clk);
        cap_clear <= 1'b0;
        for (int i = 0; i < 8; i++) acc(1'b1, cfg[i][39:32], cfg[i][31:0], 32'h0, 1'b0);
        step(3'h0, 16'h0100, 16'h0100);
        $display("reset, lock and setup test done");
        // Six-step electrical cycle, reloaded after each match
        for (int i = 0; i < 6; i++) begin
            acc(1'b1, OFS_SW_INSTR, {29'h0, rows[i].instr}, 32'h0, 1'b0);
            step(rows[i].pat, rows[i].cmp, rows[i].cmp);
            acc(1'b0, OFS_STATUS, {5'h0, rows[i].instr, 24'h0}, 32'h0700_0000, 1'b0);
        end
        $display("six step cycle test done");
        acc(1'b1, OFS_SW_SRC, 32'h0, 32'h0, 1'b0);
        acc(1'b1, OFS_QCORR, 32'h10, 32'h0, 1'b0);
        step(3'h7, 16'h0300, 16'h0310);
        acc(1'b0, OFS_STATUS, 32'h0, 32'h0700_0000, 1'b0);
        acc(1'b1, OFS_QCORR, 32'h0, 32'h0, 1'b0);
        acc(1'b1, OFS_MULT, 32'h200, 32'h0, 1'b0);
        acc(1'b1, OFS_SW_ANGLE, 32'h123, 32'h0, 1'b0);
        acc(1'b0, OFS_STATUS, 32'h246, 32'hFFFF, 1'b0);
        acc(1'b1, OFS_OFFSET, 32'h10, 32'h0, 1'b0);
        acc(1'b0, OFS_STATUS, 32'h266, 32'hFFFF, 1'b0);
        $display("angle scaling test done");
        for (int j = 6; j < 8; j++) acc(1'b1, OFS_SW_INSTR, 32'(j), 32'h0, 1'b1);
        acc(1'b0, OFS_SW_INSTR, 32'h5, 32'h7, 1'b0);
        acc(1'b0, 8'h4C, 32'h0, 32'hFFFF_FFFF, 1'b1);
        acc(1'b0, OFS_CAPTURE, 32'h8000_0000, 32'h8000_0000, 1'b0);
        diff = cap_count - rdata[23:0];
        check("capture count", 32'h1, {31'h0, cap_run && (diff < 24'h5 || diff > 24'hFFFFFB)});
        acc(1'b1, OFS_KEY, {24'h0, KEY_SHUT}, 32'h0, 1'b0);
        acc(1'b1, OFS_PATTERN, 32'h0, 32'h0, 1'b1);
        acc(1'b0, OFS_KEY, 32'h0, 32'h1, 1'b0);
        $display("refusal and capture test done");
        // Reset in mid-run returns phases and registers to their reset state
        resetn <= 1'b0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        check("phases after reset", 32'h0, {29'h0, w_phase, v_phase, u_phase});
        acc(1'b0, OFS_MULT, {16'h0, MULT_RESET}, 32'hFFFF, 1'b0);
        acc(1'b0, OFS_KEY, 32'h0, 32'h1, 1'b0);
        $display("mid-run reset test done");
        final_report();
    end
endmodule // rwpg_tb_top
`default_nettype wire
